/* File: rtl/rba_bit_addr_gen.sv */
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rba_bit_addr_gen #(
	parameter int N_PTR = rba_pkg::N_PTR,
	parameter int N_ACC = rba_pkg::N_ACC,
	parameter int ACC_W = rba_pkg::ACC_W,
	parameter int PSEL_W = $clog2(N_PTR),
	parameter int ASEL_W = $clog2(N_ACC)
) (
	input  wire logic                    clk_sys,
	input  wire logic                    reset,
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    op_valid,
	input  wire rba_pkg::rba_op_e        op_code,
	input  wire rba_pkg::rba_mode_e      op_mode,
	input  wire logic [PSEL_W-1:0]       op_ptr,
	input  wire logic [ASEL_W-1:0]       op_acc,
	output logic                         op_done,
	output logic [rba_pkg::PTR_W-1:0]    bit_addr,
	output logic                         test_flag_one,
	output logic                         test_flag_two
);
	// Short local widths
	localparam int PW = rba_pkg::PTR_W;
	localparam int OW = rba_pkg::OFS_W;
	localparam int IDX_W = $clog2(ACC_W);

	typedef struct packed {
		logic [N_PTR-1:0][PW-1:0]    ptr;
		logic [N_ACC-1:0][ACC_W-1:0] acc;
		logic [OW-1:0]               first_ofs;
		logic [OW-1:0]               second_ofs;
		logic [OW-1:0]               buf_start;
		logic [N_PTR-1:0]            circ;
		logic                        legacy;
		logic                        tf1;
		logic                        tf2;
		logic [PW-1:0]               last_addr;
		logic                        done;
		logic                        aw_got;
		logic                        w_got;
		logic [7:0]                  aw_addr;
		logic [31:0]                 w_data;
		logic [3:0]                  w_strb;
		logic                        aw_rdy;
		logic                        w_rdy;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        ar_rdy;
		logic                        rvalid;
		logic [1:0]                  rresp;
		logic [31:0]                 rdata;
	} rba_state_s;

	// Reset image built from the named reset values
	localparam rba_state_s RST_STATE = '{
		ptr:        {N_PTR{rba_pkg::PTR_RST}},
		acc:        {N_ACC{ACC_W'(rba_pkg::ACC_RST)}},
		first_ofs:  rba_pkg::OFS_RST,
		second_ofs: rba_pkg::OFS_RST,
		buf_start:  rba_pkg::OFS_RST,
		circ:       N_PTR'(rba_pkg::CIRC_RST),
		legacy:     rba_pkg::CTRL_RST,
		default:    '0
	};

	// Registered state and its next value
	rba_state_s s_r;
	rba_state_s s_nxt;

	// Operand path and bit unit results
	logic [PW-1:0]    sel_ptr;
	logic [PW-1:0]    bsa_ext;
	logic [PW-1:0]    second_ext;
	logic [PW-1:0]    base_addr;
	logic [PW-1:0]    gen_addr;
	logic [PW-1:0]    ptr_upd;
	logic [OW-1:0]    rc_amount;
	logic [OW-1:0]    rc_diff;
	logic             sel_circ;
	logic [ACC_W-1:0] unit_acc;
	logic             unit_f1;
	logic             unit_f2;

	// Readback of one word; bit 32 flags a mapped address
	function automatic logic [32:0] rd_word(input rba_state_s st,
			input logic [7:0] a);
		logic [32:0] r;
		r = {1'b1, 32'h00000000};
		if (a[7:5] == rba_pkg::PTR_BASE[7:5] && a[1:0] == 2'h0) begin
			r[31:0] = 32'(st.ptr[a[4:2]]);
		end else if (a[7:4] == rba_pkg::ACC_BASE[7:4] && a[1:0] == 2'h0) begin
			r[31:0] = 32'(st.acc[a[3:2]]);
		end else begin
			case (a)
				rba_pkg::FIRST_OFS:  r[31:0] = 32'(st.first_ofs);
				rba_pkg::SECOND_OFS: r[31:0] = 32'(st.second_ofs);
				rba_pkg::BUF_START:  r[31:0] = 32'(st.buf_start);
				rba_pkg::CIRC_CFG:   r[31:0] = 32'(st.circ);
				rba_pkg::CTRL: begin
					r[rba_pkg::CTRL_LEGACY_BIT] = st.legacy;
				end
				rba_pkg::STATUS: begin
					r[rba_pkg::STAT_TF1_BIT] = st.tf1;
					r[rba_pkg::STAT_TF2_BIT] = st.tf2;
				end
				default: r[32] = 1'b0;
			endcase
		end
		return r;
	endfunction

	// Byte-lane merge of a write into the current word
	function automatic logic [31:0] merge(input logic [31:0] o,
			input logic [31:0] d, input logic [3:0] st);
		logic [31:0] m;
		m = o;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				m[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return m;
	endfunction

	// Operand address from the pre-update pointer
	assign sel_ptr    = s_r.ptr[op_ptr];
	assign sel_circ   = s_r.circ[op_ptr];
	assign bsa_ext    = {{(PW-OW){s_r.buf_start[OW-1]}}, s_r.buf_start};
	assign second_ext = {{(PW-OW){s_r.second_ofs[OW-1]}}, s_r.second_ofs};
	assign base_addr  = sel_circ ? sel_ptr + bsa_ext : sel_ptr;
	assign gen_addr   = (op_mode == rba_pkg::MODE_INDEXED_SECOND) ?
		base_addr + second_ext : base_addr;

	// Legacy mode borrows pointer zero as the decrement step
	assign rc_amount = s_r.legacy ? s_r.ptr[0][OW-1:0] : s_r.first_ofs;

	rba_rev_carry_sub #(
		.W (OW)
	) u_rc_sub (
		.minuend    (sel_ptr[OW-1:0]),
		.subtrahend (rc_amount),
		.difference (rc_diff)
	);

	rba_bit_unit #(
		.ACC_W (ACC_W)
	) u_bit_unit (
		.op       (op_code),
		.acc_in   (s_r.acc[op_acc]),
		.bit_idx  (gen_addr[IDX_W-1:0]),
		.acc_out  (unit_acc),
		.flag_one (unit_f1),
		.flag_two (unit_f2)
	);

	// Post-modification of the pointer per mode
	always_comb begin
		case (op_mode)
			rba_pkg::MODE_REV_DEC: begin
				// Circular pointer must stay put to stay in its buffer
				ptr_upd = sel_circ ? sel_ptr :
					{sel_ptr[PW-1:OW], rc_diff};
			end
			rba_pkg::MODE_POST_INC_SECOND: begin
				ptr_upd = sel_ptr + second_ext;
			end
			rba_pkg::MODE_POST_DEC_SECOND: begin
				ptr_upd = sel_ptr - second_ext;
			end
			default: begin
				ptr_upd = sel_ptr;
			end
		endcase
	end

	// Bus slave and operation sequencing
	always_comb begin
		logic [32:0] rw;
		logic [31:0] wd;
		logic [32:0] rr;
		rw = 33'h000000000;
		wd = 32'h00000000;
		rr = 33'h000000000;
		s_nxt = s_r;
		s_nxt.done = 1'b0;

		// Address and data may arrive in either order
		if (s_axi_awvalid && s_r.aw_rdy) begin
			s_nxt.aw_got  = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.w_rdy) begin
			s_nxt.w_got  = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end

		// Commit the write once both halves are held
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			rw = rd_word(s_r, s_r.aw_addr);
			wd = merge(rw[31:0], s_r.w_data, s_r.w_strb);
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got  = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = rw[32] ? rba_pkg::RESP_OKAY :
				rba_pkg::RESP_SLVERR;
			if (rw[32]) begin
				if (s_r.aw_addr[7:5] == rba_pkg::PTR_BASE[7:5]) begin
					s_nxt.ptr[s_r.aw_addr[4:2]] = wd[PW-1:0];
				end else if (s_r.aw_addr[7:4] == rba_pkg::ACC_BASE[7:4]) begin
					s_nxt.acc[s_r.aw_addr[3:2]] = wd[ACC_W-1:0];
				end else begin
					case (s_r.aw_addr)
						rba_pkg::FIRST_OFS:  s_nxt.first_ofs  = wd[OW-1:0];
						rba_pkg::SECOND_OFS: s_nxt.second_ofs = wd[OW-1:0];
						rba_pkg::BUF_START:  s_nxt.buf_start  = wd[OW-1:0];
						rba_pkg::CIRC_CFG:   s_nxt.circ       = wd[N_PTR-1:0];
						rba_pkg::CTRL: begin
							s_nxt.legacy = wd[rba_pkg::CTRL_LEGACY_BIT];
						end
						default: begin
							s_nxt.legacy = s_nxt.legacy;
						end
					endcase
				end
			end
		end

		// Read answers one cycle after the address is taken
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_r.ar_rdy) begin
			rr = rd_word(s_r, s_axi_araddr);
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata  = rr[31:0];
			s_nxt.rresp  = rr[32] ? rba_pkg::RESP_OKAY :
				rba_pkg::RESP_SLVERR;
		end

		// Operation wins over a bus write in the same cycle
		if (op_valid) begin
			s_nxt.done      = 1'b1;
			s_nxt.last_addr = gen_addr;
			s_nxt.acc[op_acc] = unit_acc;
			if (op_code == rba_pkg::BIT_PAIR_TEST) begin
				s_nxt.tf1 = unit_f1;
				s_nxt.tf2 = unit_f2;
			end
			s_nxt.ptr[op_ptr] = ptr_upd;
		end

		// One write and one read outstanding at most
		s_nxt.aw_rdy = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.w_rdy  = !s_nxt.w_got && !s_nxt.bvalid;
		s_nxt.ar_rdy = !s_nxt.rvalid;
	end

	// Single state register; readies come up the cycle after reset
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s_r <= RST_STATE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs come straight from the state register
	assign s_axi_awready = s_r.aw_rdy;
	assign s_axi_wready  = s_r.w_rdy;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_arready = s_r.ar_rdy;
	assign s_axi_rdata   = s_r.rdata;
	assign s_axi_rresp   = s_r.rresp;
	assign s_axi_rvalid  = s_r.rvalid;
	assign op_done       = s_r.done;
	assign bit_addr      = s_r.last_addr;
	assign test_flag_one = s_r.tf1;
	assign test_flag_two = s_r.tf2;
endmodule
`default_nettype wire

/* File: rtl/rba_pkg.sv */
package rba_pkg;
	// Geometry
	localparam int N_PTR  = 8;
	localparam int N_ACC  = 4;
	localparam int PTR_W  = 23;
	localparam int OFS_W  = 16;
	localparam int ACC_W  = 32;
	localparam int ADDR_W = 8;

	// Register byte offsets
	localparam logic [7:0] PTR_BASE   = 8'h00;
	localparam logic [7:0] ACC_BASE   = 8'h20;
	localparam logic [7:0] FIRST_OFS  = 8'h30;
	localparam logic [7:0] SECOND_OFS = 8'h34;
	localparam logic [7:0] BUF_START  = 8'h38;
	localparam logic [7:0] CIRC_CFG   = 8'h3c;
	localparam logic [7:0] CTRL       = 8'h40;
	localparam logic [7:0] STATUS     = 8'h44;

	// Field positions
	localparam int CTRL_LEGACY_BIT = 0;
	localparam int STAT_TF1_BIT    = 0;
	localparam int STAT_TF2_BIT    = 1;

	// Reset values
	localparam logic [PTR_W-1:0] PTR_RST  = 23'h000000;
	localparam logic [ACC_W-1:0] ACC_RST  = 32'h00000000;
	localparam logic [OFS_W-1:0] OFS_RST  = 16'h0000;
	localparam logic [N_PTR-1:0] CIRC_RST = 8'h00;
	localparam logic             CTRL_RST = 1'h0;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		BIT_SET,
		BIT_CLEAR,
		BIT_PAIR_TEST
	} rba_op_e;

	typedef enum logic [1:0] {
		MODE_REV_DEC,
		MODE_POST_INC_SECOND,
		MODE_POST_DEC_SECOND,
		MODE_INDEXED_SECOND
	} rba_mode_e;
endpackage

/* File: rtl/rba_rev_carry_sub.sv */
`timescale 1ns/1ps
`default_nettype none
module rba_rev_carry_sub #(
	parameter int W = 16
) (
	input  wire logic [W-1:0] minuend,
	input  wire logic [W-1:0] subtrahend,
	output logic      [W-1:0] difference
);
	logic [W-1:0] a_rev;
	logic [W-1:0] b_rev;
	logic [W-1:0] d_rev;

	// Mirror operands so the borrow ripples MSB to LSB
	genvar i;
	for (i = 0; i < W; i++) begin : g_rev
		assign a_rev[i]      = minuend[W-1-i];
		assign b_rev[i]      = subtrahend[W-1-i];
		assign difference[i] = d_rev[W-1-i];
	end

	assign d_rev = a_rev - b_rev;
endmodule
`default_nettype wire

/* File: rtl/rba_bit_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module rba_bit_unit #(
	parameter int ACC_W = 32,
	parameter int IDX_W = $clog2(ACC_W)
) (
	input  wire rba_pkg::rba_op_e op,
	input  wire logic [ACC_W-1:0] acc_in,
	input  wire logic [IDX_W-1:0] bit_idx,
	output logic      [ACC_W-1:0] acc_out,
	output logic                  flag_one,
	output logic                  flag_two
);
	logic [IDX_W-1:0] next_idx;

	// Pair partner wraps inside the accumulator
	assign next_idx = bit_idx + 1'b1;
	assign flag_one = acc_in[bit_idx];
	assign flag_two = acc_in[next_idx];

	// Only the addressed bit is touched
	always_comb begin
		acc_out = acc_in;
		case (op)
			rba_pkg::BIT_SET: begin
				acc_out[bit_idx] = 1'b1;
			end
			rba_pkg::BIT_CLEAR: begin
				acc_out[bit_idx] = 1'b0;
			end
			default: begin
				acc_out = acc_in;
			end
		endcase
	end
endmodule
`default_nettype wire

/* File: testbench/rba_bit_addr_gen_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module rba_bit_addr_gen_sva (
	input wire logic              clk_sys,
	input wire logic              reset,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              op_valid,
	input wire rba_pkg::rba_op_e  op_code,
	input wire logic              op_done,
	input wire logic [22:0]       bit_addr,
	input wire logic              test_flag_one,
	input wire logic              test_flag_two
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Handshake steps of the two bus directions
	sequence s_wtake; s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready; endsequence
	sequence s_rtake; s_axi_arvalid && s_axi_arready; endsequence
	property p_bresp; s_wtake |-> ##2 s_axi_bvalid; endproperty
	property p_rresp; s_rtake |=> s_axi_rvalid; endproperty
	property p_rhold; s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	property p_bhold; s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	property p_rblk; s_axi_rvalid |-> !s_axi_arready; endproperty
	property p_bblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
		endproperty
	property p_done; op_valid |=> op_done; endproperty
	property p_nodone; !op_valid |=> !op_done; endproperty
	// Flags only move on a pair test, never on set or clear
	property p_flag; !(op_valid && op_code == rba_pkg::BIT_PAIR_TEST)
		|=> $stable({test_flag_two, test_flag_one}); endproperty
	property p_addr; !op_valid |=> $stable(bit_addr); endproperty
	a_bresp: assert property (p_bresp) else $error("late write answer");
	a_rresp: assert property (p_rresp) else $error("late read answer");
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	a_rblk: assert property (p_rblk) else $error("read taken while busy");
	a_bblk: assert property (p_bblk) else $error("write taken while busy");
	a_done: assert property (p_done) else $error("no done pulse");
	a_nodone: assert property (p_nodone) else $error("stray done pulse");
	a_flag: assert property (p_flag) else $error("flags moved");
	a_addr: assert property (p_addr) else $error("address moved");
endmodule
bind rba_bit_addr_gen rba_bit_addr_gen_sva u_sva (.clk_sys, .reset,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .op_valid,
	.op_code, .op_done, .bit_addr, .test_flag_one, .test_flag_two);
`default_nettype wire

/* File: testbench/rba_dec_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rba_dec_model (
	input wire logic           clk_sys,
	output rba_pkg::rba_op_e   op_code,
	output rba_pkg::rba_mode_e op_mode,
	output logic               op_valid,
	output logic [2:0]         op_ptr,
	output logic [1:0]         op_acc
);
	initial begin
		op_valid = 1'b0;
		op_code = rba_pkg::BIT_SET;
		op_mode = rba_pkg::MODE_REV_DEC;
		op_ptr = 3'h0;
		op_acc = 2'h0;
	end
	// One op per call; pointer and accumulator fields scrambled when idle so stale selects hide nothing
	task automatic issue(input rba_pkg::rba_op_e c,
		input rba_pkg::rba_mode_e m, input logic [2:0] p, input logic [1:0] a);
		@(posedge clk_sys);
		op_valid <= 1'b1;
		op_code <= c;
		op_mode <= m;
		op_ptr <= p;
		op_acc <= a;
		@(posedge clk_sys);
		op_valid <= 1'b0;
		op_ptr <= ~p;
		op_acc <= ~a;
	endtask
endmodule
`default_nettype wire

/* File: testbench/tb_rba_bit_addr_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_rba_bit_addr_gen;
	logic clk_sys = 0, reset = 1, op_valid, op_done, test_flag_one, test_flag_two;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, op_acc;
	logic [2:0] op_ptr;
	logic [22:0] bit_addr;
	logic [15:0] e1, e2;
	rba_pkg::rba_op_e op_code;
	rba_pkg::rba_mode_e op_mode;
	int error_cnt = 0, total_checks = 0, cyc = 0;
	localparam logic [1:0] OK = rba_pkg::RESP_OKAY, ERR = rba_pkg::RESP_SLVERR;
	always #4 clk_sys = ~clk_sys;
	rba_bit_addr_gen u_rba_bit_addr_gen (.clk_sys, .reset, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_valid,
		.op_code, .op_mode, .op_ptr, .op_acc, .op_done, .bit_addr,
		.test_flag_one, .test_flag_two);
	rba_dec_model u_rba_dec_model (.clk_sys, .op_code, .op_mode, .op_valid,
		.op_ptr, .op_acc);
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Hang guard, far above the roughly 150 cycles the tests need
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic chk(input logic [31:0] g, e, input string m);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = OK);
		@(posedge clk_sys);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er, "bresp");
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er = OK);
		@(posedge clk_sys);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, e, "rdata");
		chk(s_axi_rresp, er, "rresp");
	endtask
	// Done and address are looked at in the one cycle the pulse stands
	task automatic op(input rba_pkg::rba_op_e c, input rba_pkg::rba_mode_e m,
		input logic [2:0] p, input logic [1:0] a, input logic [22:0] ea);
		u_rba_dec_model.issue(c, m, p, a);
		@(posedge clk_sys);
		chk(op_done, 1, "done");
		chk(bit_addr, ea, "bit address");
	endtask
	task automatic t_rev;
		wr(8'h3c, 0);
		wr(8'h30, 8);
		wr(8'h08, 0);
		op(rba_pkg::BIT_SET, rba_pkg::MODE_REV_DEC, 2, 3, 0);
		rd(8'h2c, 1);
		e1 = 16'h000f; // Borrow from bit 3 runs down past bit 0
		rd(8'h08, e1);
		wr(8'h00, 4);
		wr(8'h40, 1);
		op(rba_pkg::BIT_SET, rba_pkg::MODE_REV_DEC, 2, 3, e1);
		rd(8'h2c, 32'h1 | (32'h1 << e1[4:0]));
		e2 = 16'h000b; // Bit 2 taken away, no borrow
		rd(8'h08, e2);
		wr(8'h40, 0);
		wr(8'h3c, 4);
		wr(8'h38, 32'h8001);
		op(rba_pkg::BIT_PAIR_TEST, rba_pkg::MODE_REV_DEC, 2, 3,
			{7'h0, e2} + 23'h7f8001);
		rd(8'h08, e2);
		wr(8'h3c, 0);
		$display("t_rev done");
	endtask
	task automatic t_post;
		wr(8'h34, 32'hfffe);
		wr(8'h10, 32'h10);
		wr(8'h28, 32'hffffffff);
		op(rba_pkg::BIT_CLEAR, rba_pkg::MODE_POST_INC_SECOND, 4, 2, 23'h10);
		rd(8'h10, 32'he);
		rd(8'h28, 32'hfffeffff);
		op(rba_pkg::BIT_CLEAR, rba_pkg::MODE_POST_DEC_SECOND, 4, 2, 23'he);
		rd(8'h10, 32'h10);
		rd(8'h28, 32'hfffebfff);
		$display("t_post done");
	endtask
	task automatic t_idx;
		wr(8'h34, 5);
		wr(8'h04, 25);
		wr(8'h28, 32'h40000000);
		op(rba_pkg::BIT_PAIR_TEST, rba_pkg::MODE_INDEXED_SECOND, 1, 2, 30);
		chk({test_flag_two, test_flag_one}, 1, "flags");
		rd(8'h04, 25);
		rd(8'h44, 1);
		wr(8'h04, 26);
		wr(8'h28, 1);
		op(rba_pkg::BIT_PAIR_TEST, rba_pkg::MODE_INDEXED_SECOND, 1, 2, 31);
		chk({test_flag_two, test_flag_one}, 2, "flags");
		rd(8'h28, 1);
		$display("t_idx done");
	endtask
	task automatic t_bus;
		rd(8'h48, 0, ERR);
		wr(8'h48, 1, ERR);
		wr(8'h44, 0);
		rd(8'h44, 2);
		$display("t_bus done");
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rd(8'h20, 0);
		t_rev();
		t_post();
		t_idx();
		t_bus();
		close_out();
	end
endmodule
`default_nettype wire
